// ---- design/spic_fifo.sv ----
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: count output is one bit wider than the pointers
`timescale 1ns/1ns
module spic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign o_count = count;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- design/spic_link.sv ----
// Purpose: serial shifter on the link clock, one byte per eight clock edges
// Assumes: mosi and select change away from the rising link clock edge
// Notes: a byte cut short by select is dropped at the next link clock edge taken while deselected
`timescale 1ns/1ns
module spic_link (
  input wire logic i_sck,
  input wire logic i_reset,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_lsb_first,
  input wire logic [7:0] i_tx_byte,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [7:0] o_rx_byte,
  output logic o_rx_toggle,
  output logic o_take_toggle
);
  logic [1:0] rst_sync;
  logic [1:0] lsb_sync;
  spic_pkg::spic_lnk_t state;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  wire lnk_rst = rst_sync[1];
  wire lsb = lsb_sync[1];
  wire [7:0] next_rx_sh = lsb ? {i_mosi, rx_sh[7:1]} : {rx_sh[6:0], i_mosi};
  wire [7:0] tx_src = (state == spic_pkg::LNK_IDLE) ? i_tx_byte : tx_sh;
  wire [7:0] next_tx_sh = lsb ? {1'b0, tx_src[7:1]} : {tx_src[6:0], 1'b0};

  // first bit comes straight from the hold word, which is stable by then
  assign o_miso = lsb ? tx_src[0] : tx_src[7];
  assign o_miso_oe = ~i_ss_n;

  ////////////////////////////////////////////////////////////////////////
  // reset and bit order cross in as levels
  always_ff @(posedge i_sck) begin
    rst_sync <= {rst_sync[0], i_reset};
    lsb_sync <= {lsb_sync[0], i_lsb_first};
  end

  always_ff @(posedge i_sck) begin
    if (lnk_rst || i_ss_n) begin
      state <= spic_pkg::LNK_IDLE;
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      state <= (bit_cnt == 3'h7) ? spic_pkg::LNK_IDLE : spic_pkg::LNK_SHIFT;
    end
  end

  always_ff @(posedge i_sck) begin
    if (lnk_rst) begin
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      o_rx_byte <= 8'h00;
      o_rx_toggle <= 1'b0;
      o_take_toggle <= 1'b0;
    end else if (!i_ss_n) begin
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      if (state == spic_pkg::LNK_IDLE) begin
        o_take_toggle <= ~o_take_toggle;
      end
      if (bit_cnt == 3'h7) begin
        o_rx_byte <= next_rx_sh;
        o_rx_toggle <= ~o_rx_toggle;
      end
    end
  end
endmodule

// ---- design/spic_top.sv ----
// Purpose: serial port unit configuration, FIFO requests and exception gating
// Assumes: register port is the internal bus, 32-bit data, byte enables
// Notes: irq outputs are registered, one cycle behind the FIFO levels
`timescale 1ns/1ns
// Function
// R1: control bits 15:14 hold a read/write transmit threshold, reset 00.
// R2: transmit request rises when at least code+1 more values fit in the transmit FIFO.
// R3: software should pick transmit code 00 when DMA feeds the transmitter.
// R4: control bits 13:12 hold the receive threshold; request once code+1 values are held.
// R5: software should pick receive code 00 when DMA drains the receiver.
// R6: bit 11 lets the idle flag drive the shared exception interrupt.
// R7: bit 10 lets the overflow flag drive the shared exception interrupt.
// R8: bit 9 lets the underflow flag drive the shared exception interrupt.
// R9: bit 8 lets the format error flag drive the shared exception interrupt.
// R10: bit 5 at 0 makes select valid in master mode so it can raise a format error.
// R11: bit 4 at 1 runs the inter-frame gap prescaler.
// R12: bits 31:16 of every register read zero; byte, half-word and word accesses work.
// R13: software enters configuration mode before changing master, order, phase, polarity.
// R14: shared exception is high while any flag and its enable are both set.
// R15: both FIFO requests follow the FIFO levels continuously and drop when unmet.
module spic_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [3:0] I_REG_BE,
  input wire logic [31:0] I_REG_WDATA,
  output logic [31:0] O_REG_RDATA,
  output logic O_TX_READY,
  output logic O_TX_SPACE_IRQ,
  output logic O_RX_LEVEL_IRQ,
  output logic O_SHARED_EXCEPTION_IRQ,
  output logic O_FRAME_GAP_TICK,
  input wire logic I_LINK_SCK,
  input wire logic I_LINK_SS_N,
  input wire logic I_LINK_MOSI,
  output logic O_LINK_MISO,
  output logic O_LINK_MISO_OE
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  spic_pkg::spic_ctrl_t ctrl;
  spic_pkg::spic_flags_t flags;
  spic_pkg::spic_hold_t hold_state;
  logic [7:0] tx_hold;
  logic [2:0] rx_tgl_sync;
  logic [2:0] take_tgl_sync;
  logic [1:0] ss_sync;
  logic [$clog2(spic_pkg::GAP_PRESCALE_CYC)-1:0] gap_cnt;
  logic [7:0] lnk_rx_byte;
  logic lnk_rx_toggle;
  logic lnk_take_toggle;
  logic tx_out_valid;
  logic [7:0] tx_out_data;
  logic [spic_pkg::FIFO_CW-1:0] tx_count;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [7:0] rx_out_data;
  logic [spic_pkg::FIFO_CW-1:0] rx_count;

  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    byte_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register decode
  wire sel_ctrl = (I_REG_ADDR == spic_pkg::ADDR_CTRL0);
  wire sel_status = (I_REG_ADDR == spic_pkg::ADDR_STATUS);
  wire sel_data = (I_REG_ADDR == spic_pkg::ADDR_DATA);
  wire wr_ctrl = I_REG_WR && sel_ctrl;
  wire wr_status = I_REG_WR && sel_status;
  wire wr_data = I_REG_WR && sel_data && I_REG_BE[0];
  wire rd_data = I_REG_RD && sel_data;
  wire [15:0] clear_bits = byte_merge(16'h0000, I_REG_WDATA, I_REG_BE);

  ////////////////////////////////////////////////////////////////////////
  // link events cross over as toggles
  wire rx_evt = rx_tgl_sync[2] ^ rx_tgl_sync[1];
  wire take_evt = take_tgl_sync[2] ^ take_tgl_sync[1];
  wire ss_active = ~ss_sync[1];

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      rx_tgl_sync <= 3'h0;
      take_tgl_sync <= 3'h0;
      ss_sync <= 2'h3;
    end else begin
      rx_tgl_sync <= {rx_tgl_sync[1:0], lnk_rx_toggle};
      take_tgl_sync <= {take_tgl_sync[1:0], lnk_take_toggle};
      ss_sync <= {ss_sync[0], I_LINK_SS_N};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // FIFOs; software write fills transmit, link fills receive
  wire tx_pop = (hold_state == spic_pkg::HOLD_EMPTY) || take_evt;

  spic_fifo #(
    .WIDTH(spic_pkg::FIFO_WIDTH),
    .DEPTH(spic_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_in_valid(wr_data),
    .o_in_ready(O_TX_READY),
    .i_in_data(I_REG_WDATA[7:0]),
    .o_out_valid(tx_out_valid),
    .i_out_ready(tx_pop),
    .o_out_data(tx_out_data),
    .o_count(tx_count)
  );

  spic_fifo #(
    .WIDTH(spic_pkg::FIFO_WIDTH),
    .DEPTH(spic_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_in_valid(rx_evt),
    .o_in_ready(rx_in_ready),
    .i_in_data(lnk_rx_byte),
    .o_out_valid(rx_out_valid),
    .i_out_ready(rd_data),
    .o_out_data(rx_out_data),
    .o_count(rx_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit hold word, refilled each time the link takes one
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      hold_state <= spic_pkg::HOLD_EMPTY;
      tx_hold <= 8'h00;
    end else if (tx_pop && tx_out_valid) begin
      hold_state <= spic_pkg::HOLD_FULL;
      tx_hold <= tx_out_data;
    end else if (take_evt) begin
      hold_state <= spic_pkg::HOLD_EMPTY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      // R1: threshold resets to 00
      ctrl <= spic_pkg::CTRL0_RESET;
    end else if (wr_ctrl) begin
      // R12: byte lanes 0 and 1 only
      ctrl <= byte_merge(ctrl, I_REG_WDATA, I_REG_BE) & spic_pkg::CTRL0_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags; a new event beats a clear in the same cycle
  wire ovf_set = rx_evt && !rx_in_ready;
  wire unf_set = take_evt && (hold_state == spic_pkg::HOLD_EMPTY);
  // R10: select counts in master mode only while bit 5 is 0
  wire fmt_set = ctrl.master_select && !ctrl.select_input_valid && ss_active;
  wire idle_now = !ss_active && (tx_count == '0) && (hold_state == spic_pkg::HOLD_EMPTY);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      flags <= '0;
    end else begin
      flags.idle_flag <= idle_now;
      flags.overflow_error_flag <= ovf_set ||
        (flags.overflow_error_flag && !(wr_status && clear_bits[spic_pkg::ST_OVF_BIT]));
      flags.underflow_error_flag <= unf_set ||
        (flags.underflow_error_flag && !(wr_status && clear_bits[spic_pkg::ST_UNF_BIT]));
      flags.format_error_flag <= fmt_set ||
        (flags.format_error_flag && !(wr_status && clear_bits[spic_pkg::ST_FMT_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt requests
  wire [4:0] tx_space = spic_pkg::FIFO_DEPTH_W - tx_count;
  // R2: code+1 free entries needed
  wire tx_req = tx_space >= ({3'h0, ctrl.tx_space_threshold} + 5'h01);
  // R4: code+1 stored values needed
  wire rx_req = rx_count >= ({3'h0, ctrl.rx_level_threshold} + 5'h01);
  // R6 R7 R8 R9: per-flag enables
  wire [3:0] exc_src = {ctrl.idle_irq_enable && flags.idle_flag,
                        ctrl.overflow_irq_enable && flags.overflow_error_flag,
                        ctrl.underflow_irq_enable && flags.underflow_error_flag,
                        ctrl.format_error_irq_enable && flags.format_error_flag};

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_TX_SPACE_IRQ <= 1'b0;
      O_RX_LEVEL_IRQ <= 1'b0;
      O_SHARED_EXCEPTION_IRQ <= 1'b0;
    end else begin
      // R15: level-following, no latching
      O_TX_SPACE_IRQ <= tx_req;
      O_RX_LEVEL_IRQ <= rx_req;
      // R14: any enabled flag
      O_SHARED_EXCEPTION_IRQ <= |exc_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // inter-frame gap prescaler, stopped and cleared while disabled
  wire gap_wrap = (gap_cnt == ($bits(gap_cnt))'(spic_pkg::GAP_PRESCALE_CYC - 1));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      gap_cnt <= '0;
      O_FRAME_GAP_TICK <= 1'b0;
    end else begin
      // R11: runs only when enabled
      gap_cnt <= (!ctrl.frame_gap_prescale_enable || gap_wrap) ? '0 : gap_cnt + 1'b1;
      O_FRAME_GAP_TICK <= ctrl.frame_gap_prescale_enable && gap_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; upper half always zero
  wire [15:0] status_word = {rx_req, tx_req, rx_count, tx_count, flags};
  wire [15:0] rd_mux = sel_ctrl ? ctrl :
                       sel_status ? status_word :
                       sel_data ? {8'h00, rx_out_data} : 16'h0000;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_REG_RDATA <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      // R12: bits 31:16 wired to zero
      O_REG_RDATA <= {16'h0000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link side
  spic_link u_link (
    .i_sck(I_LINK_SCK),
    .i_reset(I_RESET),
    .i_ss_n(I_LINK_SS_N),
    .i_mosi(I_LINK_MOSI),
    .i_lsb_first(ctrl.bit_order_select),
    .i_tx_byte(tx_hold),
    .o_miso(O_LINK_MISO),
    .o_miso_oe(O_LINK_MISO_OE),
    .o_rx_byte(lnk_rx_byte),
    .o_rx_toggle(lnk_rx_toggle),
    .o_take_toggle(lnk_take_toggle)
  );
endmodule

// ---- inc/spic_pkg.sv ----
// Purpose: shared constants and types of the serial port unit configuration block
// Assumes: 8-bit serial frames, 16-entry transmit and receive FIFOs
// Notes: register offsets are byte addresses on the internal register port
package spic_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;
  localparam logic [15:0] CTRL0_RESET = 16'h0000;
  // control bits 7:6 are reserved and read as zero
  localparam logic [15:0] CTRL0_WMASK = 16'hFF3F;

  // status register layout
  localparam int ST_IDLE_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_UNF_BIT = 2;
  localparam int ST_FMT_BIT = 3;
  localparam int ST_TXLVL_LSB = 4;
  localparam int ST_RXLVL_LSB = 9;
  localparam int ST_TXIRQ_BIT = 14;
  localparam int ST_RXIRQ_BIT = 15;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_CW = 5;
  localparam logic [4:0] FIFO_DEPTH_W = 5'h10;

  // frame gap prescaler period
  localparam int CORE_CLK_MHZ = 250;
  localparam int GAP_PRESCALE_NS = 64;
  localparam int GAP_PRESCALE_CYC = (GAP_PRESCALE_NS * CORE_CLK_MHZ) / 1000;

  typedef struct packed {
    logic [1:0] tx_space_threshold;
    logic [1:0] rx_level_threshold;
    logic idle_irq_enable;
    logic overflow_irq_enable;
    logic underflow_irq_enable;
    logic format_error_irq_enable;
    logic [1:0] reserved;
    logic select_input_valid;
    logic frame_gap_prescale_enable;
    logic master_select;
    logic bit_order_select;
    logic clock_phase;
    logic clock_polarity;
  } spic_ctrl_t;

  typedef struct packed {
    logic format_error_flag;
    logic underflow_error_flag;
    logic overflow_error_flag;
    logic idle_flag;
  } spic_flags_t;

  typedef enum logic [1:0] {
    HOLD_EMPTY = 2'b01,
    HOLD_FULL = 2'b10
  } spic_hold_t;

  typedef enum logic [1:0] {
    LNK_IDLE = 2'b01,
    LNK_SHIFT = 2'b10
  } spic_lnk_t;
endpackage

// ---- tb/spic_link_model.sv ----
// Purpose: link master driving select, clock and serial data
// Assumes: msb first, clock stands still outside frames
// Notes: run gives free clock edges for the link reset only
`timescale 1ns/1ns
module spic_link_model (
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic run(input int n);
    repeat (n) begin
      #15 o_sck = 1'b1;
      #15 o_sck = 1'b0;
    end
  endtask
  task automatic sel(input logic v);
    o_ss_n = !v;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      // sample before the rising edge; the shifter moves on right after it
      #15 rx[i] = i_miso & i_miso_oe;
      o_sck = 1'b1;
      #15 o_sck = 1'b0;
    end
    o_ss_n = 1'b1;
    // released line shows the inverse, not a held value
    o_mosi = !o_mosi;
    #30;
  endtask
endmodule

// ---- tb/spic_props.sv ----
// Purpose: port checks of the serial port configuration block
// Assumes: a shadow of ctrl is rebuilt from register writes
// Notes: registered irqs are judged against ctrl one cycle back
`timescale 1ns/1ns
module spic_props (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [3:0] I_REG_BE,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic O_TX_READY,
  input wire logic O_TX_SPACE_IRQ,
  input wire logic O_RX_LEVEL_IRQ,
  input wire logic O_SHARED_EXCEPTION_IRQ,
  input wire logic O_FRAME_GAP_TICK,
  input wire logic I_LINK_SS_N,
  input wire logic O_LINK_MISO_OE
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RESET);
  logic [15:0] sh;
  wire ctrl_wr = I_REG_WR && I_REG_ADDR == spic_pkg::ADDR_CTRL0;
  wire [7:0] next_hi = I_REG_BE[1] ? I_REG_WDATA[15:8] : sh[15:8];
  wire [7:0] next_lo = I_REG_BE[0] ? I_REG_WDATA[7:0] : sh[7:0];
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      sh <= spic_pkg::CTRL0_RESET;
    end else if (ctrl_wr) begin
      sh <= {next_hi, next_lo} & spic_pkg::CTRL0_WMASK;
    end
  end
  ////////////////////////////////////////////////////////////////
  upper_zero_a: assert property (O_REG_RDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");
  ctrl_readback_a: assert property ((ctrl_wr && I_REG_BE[1:0] == 2'b11)
    ##1 (I_REG_RD && !I_REG_WR && I_REG_ADDR == spic_pkg::ADDR_CTRL0)
    |=> O_REG_RDATA[15:0] == ($past(I_REG_WDATA[15:0], 2) & spic_pkg::CTRL0_WMASK))
    else $error("ctrl readback wrong");
  tx_full_a: assert property (!$past(I_RESET) && !$past(O_TX_READY) |-> !O_TX_SPACE_IRQ)
    else $error("tx request with no space");
  tx_code_zero_a: assert property (!$past(I_RESET) && $past(O_TX_READY)
    && $past(sh[15:14]) == 2'b00 |-> O_TX_SPACE_IRQ)
    else $error("tx request missing with space");
  exc_source_a: assert property (O_SHARED_EXCEPTION_IRQ |-> $past(sh[11:8]) != 4'h0)
    else $error("exception with all sources off");
  tick_enable_a: assert property (O_FRAME_GAP_TICK |-> $past(sh[4]) || $past(sh[4], 2))
    else $error("tick with prescaler off");
  tick_gap_a: assert property (O_FRAME_GAP_TICK && sh[4] |-> ##16 (O_FRAME_GAP_TICK || !sh[4]))
    else $error("tick period wrong");
  tick_quiet_a: assert property (O_FRAME_GAP_TICK |=> !O_FRAME_GAP_TICK [*8])
    else $error("tick too soon");
  miso_oe_a: assert property (O_LINK_MISO_OE == !I_LINK_SS_N)
    else $error("miso enable not following select");
  cover property (O_FRAME_GAP_TICK);
  cover property (O_RX_LEVEL_IRQ);
  cover property (!O_TX_READY);
  cover property (O_SHARED_EXCEPTION_IRQ);
endmodule
bind spic_top spic_props spic_props_inst (.*);

// ---- tb/spic_top_tb.sv ----
// Purpose: register and link scenarios for the configuration block
// Assumes: link clock runs through reset, so reset spans ten link periods
// Notes: expected levels follow the fifo fill reached by each step
`timescale 1ns/1ns
module spic_top_tb;
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic tx_ready, tx_irq, rx_irq, exc_irq, tick, sck, ss_n, mosi, miso, miso_oe;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  spic_top spic_top_inst (
    .I_CORE_CLK(clk),
    .I_RESET(rst),
    .I_REG_ADDR(addr),
    .I_REG_WR(wr),
    .I_REG_RD(rd),
    .I_REG_BE(be),
    .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata),
    .O_TX_READY(tx_ready),
    .O_TX_SPACE_IRQ(tx_irq),
    .O_RX_LEVEL_IRQ(rx_irq),
    .O_SHARED_EXCEPTION_IRQ(exc_irq),
    .O_FRAME_GAP_TICK(tick),
    .I_LINK_SCK(sck),
    .I_LINK_SS_N(ss_n),
    .I_LINK_MOSI(mosi),
    .O_LINK_MISO(miso),
    .O_LINK_MISO_OE(miso_oe)
  );
  spic_link_model spic_link_model_inst (
    .o_sck(sck),
    .o_ss_n(ss_n),
    .o_mosi(mosi),
    .i_miso(miso),
    .i_miso_oe(miso_oe)
  );
  ////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    addr = a;
    wdata = d;
    be = b;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
    d = rdata;
  endtask
  task automatic ctrl(input logic [15:0] v);
    wreg(spic_pkg::ADDR_CTRL0, {16'h0000, v}, 4'hF);
    step(2);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [7:0] r;
    int n;
    fork
      step(10);
      spic_link_model_inst.run(10);
    join
    step(1);
    rst = 1'b0;
    // link reset is synchronised on its own clock, so it needs edges after release
    spic_link_model_inst.run(3);
    step(1);
    rreg(spic_pkg::ADDR_CTRL0, d);
    `CHK(d, 32'h0000_0000)
    rreg(8'h00, d);
    `CHK(d, 32'h0000_0000)
    wreg(spic_pkg::ADDR_CTRL0, 32'hFFFF_FFFF, 4'hF);
    rreg(spic_pkg::ADDR_CTRL0, d);
    `CHK(d, {16'h0000, spic_pkg::CTRL0_WMASK})
    wreg(spic_pkg::ADDR_CTRL0, 32'h0000_0000, 4'h1);
    rreg(spic_pkg::ADDR_CTRL0, d);
    `CHK(d, {16'h0000, spic_pkg::CTRL0_WMASK & 16'hFF00})
    for (int e = 1; e >= 0; e--) begin
      ctrl({11'h000, e[0], 4'h0});
      n = 0;
      repeat (160) begin
        step(1);
        n += int'(tick);
      end
      `CHK(n, 10 * e)
    end
    ctrl(16'h0800);
    `CHK(exc_irq, 1'b1)
    ctrl(16'h0700);
    `CHK(exc_irq, 1'b0)
    n = 0;
    while (tx_ready === 1'b1 && n < 40) begin
      wreg(spic_pkg::ADDR_DATA, {24'h00_0000, 8'hA0 + n[7:0]}, 4'h1);
      step(1);
      n++;
    end
    // each frame frees one tx entry and stores one rx value
    // code 00 included
    for (int k = 0; k <= 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        ctrl({c[1:0], c[1:0], 12'h000});
        `CHK(tx_irq, k > c)
        `CHK(rx_irq, k > c)
      end
      if (k < 4) begin
        spic_link_model_inst.xfer(8'h51 + k[7:0], r);
        `CHK(r, 8'hA0 + k[7:0])
        step(8);
      end
    end
    for (int k = 0; k < 4; k++) begin
      rreg(spic_pkg::ADDR_DATA, d);
      `CHK(d, {24'h000000, 8'h51 + k[7:0]})
    end
    ctrl(16'h0000);
    `CHK(rx_irq, 1'b0)
    // draining tx past empty while rx overfills
    repeat (30) spic_link_model_inst.xfer(8'h3C, r);
    step(8);
    rreg(spic_pkg::ADDR_STATUS, d);
    `CHK(d[2:1], 2'b11)
    for (int b = 0; b < 4; b++) begin
      ctrl(16'h0100 << b);
      `CHK(exc_irq, b > 0)
    end
    ctrl(16'hF000);
    `CHK(tx_irq, 1'b1)
    `CHK(rx_irq, 1'b1)
    wreg(spic_pkg::ADDR_STATUS, 32'h0000_000E, 4'h1);
    step(1);
    ctrl(16'h0600);
    `CHK(exc_irq, 1'b0)
    ctrl(16'h0108);
    spic_link_model_inst.sel(1'b1);
    step(8);
    `CHK(exc_irq, 1'b1)
    spic_link_model_inst.sel(1'b0);
    step(6);
    wreg(spic_pkg::ADDR_STATUS, 32'h0000_0008, 4'h1);
    step(1);
    ctrl(16'h0128);
    spic_link_model_inst.sel(1'b1);
    step(8);
    `CHK(exc_irq, 1'b0)
    spic_link_model_inst.sel(1'b0);
    report_and_stop();
  end
endmodule
